// ==== shared/ics_consts.svh ====
// register offsets, field positions, reset values for the interrupt status block
`ifndef ICS_CONSTS_SVH
`define ICS_CONSTS_SVH

// ==========================================
// register map (byte addresses)
`define ICS_ADDR_W 8
`define ICS_OFS_MASK 8'h30
`define ICS_OFS_RAW 8'h38
`define ICS_OFS_ISC 8'h3c
`define ICS_OFS_TX_LVL 8'h40
`define ICS_OFS_RX_LVL 8'h44

// ==========================================
// event field positions
`define ICS_NUM_EVT 13
`define ICS_BIT_RX_UNDER 0
`define ICS_BIT_RX_OVER 1
`define ICS_BIT_RX_HIGH 2
`define ICS_BIT_TX_OVER 3
`define ICS_BIT_TX_LOW 4
`define ICS_BIT_RD_REQ 5
`define ICS_BIT_TX_ABORT 6
`define ICS_BIT_SLV_DONE 7
`define ICS_BIT_ACTIVITY 8
`define ICS_BIT_STOP 9
`define ICS_BIT_START 10
`define ICS_BIT_GEN_CALL 11
`define ICS_BIT_TIMEOUT 12

// ==========================================
// widths and reset values
`define ICS_DATA_W 32
`define ICS_LVL_W 8
`define ICS_LVL_RESET 8'h00
`define ICS_MASK_RESET 13'h0000
`define ICS_FLAG_RESET 1'b0
`define ICS_RDATA_RESET 32'h0000_0000

`endif

// ==== shared/ics_pkg.sv ====
// types shared by the interrupt status block
`include "ics_consts.svh"
package ics_pkg;
	typedef logic [`ICS_NUM_EVT-1:0] ics_evt_t;
	typedef logic [`ICS_LVL_W-1:0] ics_lvl_t;
	typedef logic [`ICS_DATA_W-1:0] ics_word_t;
	typedef logic [`ICS_ADDR_W-1:0] ics_addr_t;
	typedef enum logic [2:0] {
		ICS_SEL_NONE = 3'h0,
		ICS_SEL_MASK = 3'h1,
		ICS_SEL_RAW = 3'h3,
		ICS_SEL_ISC = 3'h2,
		ICS_SEL_TX_LVL = 3'h6,
		ICS_SEL_RX_LVL = 3'h7
	} ics_sel_t;
endpackage

// ==== shared/ics_lvl_if.sv ====
// write port and stored value of one threshold level register
interface ics_lvl_if;
	logic wr;
	ics_pkg::ics_lvl_t wdata;
	ics_pkg::ics_lvl_t level;
	modport store(input wr, input wdata, output level);
	modport user(output wr, output wdata, input level);
endinterface

// ==== rtl/ics_flag.sv ====
// one sticky event flag, set by hardware, cleared by a software write of one
`include "ics_consts.svh"
module ics_flag #(
	parameter logic RESET_VAL = `ICS_FLAG_RESET
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_set,
	input wire logic i_clr,
	output logic o_flag
);
	logic flag_reg;
	logic flag_next;

	// a set in the same cycle as the clear wins, so no event is lost
	always_comb begin
		flag_next = i_set | (flag_reg & ~i_clr);
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			flag_reg <= RESET_VAL;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign o_flag = flag_reg;
endmodule

// ==== rtl/ics_level_reg.sv ====
// one 8-bit read-write threshold level register
`include "ics_consts.svh"
module ics_level_reg #(
	parameter ics_pkg::ics_lvl_t RESET_VAL = `ICS_LVL_RESET
) (
	input wire logic i_clk,
	input wire logic i_reset,
	ics_lvl_if.store lvl
);
	ics_pkg::ics_lvl_t level_reg;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			level_reg <= RESET_VAL;
		end else if (lvl.wr) begin
			level_reg <= lvl.wdata;
		end
	end

	assign lvl.level = level_reg;
endmodule

// ==== rtl/ics_top.sv ====
// interrupt status, mask and fifo threshold registers of the serial bus controller
//
// Implementation choice: the plain strobed port.
`include "ics_consts.svh"
// ==========================================
// Functional notes
// [RULE1]: bit 12 of the status register shows the timeout event and a written one clears it.
// [RULE2]: a status bit reads one only for an event that is both pending and unmasked.
// [RULE3]: bits 31 to 13 of the status register read zero and ignore writes.
// [RULE4]: bit 11 shows the general call event, cleared by a written one, zero after reset.
// [RULE5]: bit 10 shows a start condition and bit 9 a stop condition, both clear on one, reset zero.
// [RULE6]: bit 8 shows bus activity and bit 7 slave transmit done, both clear on one, reset zero.
// [RULE7]: bit 6 shows a transmit abort and bit 5 a slave read request, both clear on one, reset zero.
// [RULE8]: bit 4 shows transmit fifo at or below level and bit 3 transmit overflow, clear on one.
// [RULE9]: bits 2, 1 and 0 show receive high level, receive overflow and underflow, clear on one.
// [RULE10]: the register at 0x40 holds the transmit low level, reset zero, upper bits read zero.
// [RULE11]: the next register holds the receive high level, reset zero, upper bits read zero.
// [RULE12]: the receive high event is raised while the receive fill reaches or passes its level.
// [RULE13]: the timeout event is raised when the bus is busy and the clock line stayed low too long.
// [RULE14]: each status bit is the raw flag and its mask bit, and a clear drops both views.
module ics_top (
	input wire logic I_CLK,
	input wire logic I_RESET,
	input wire logic [`ICS_ADDR_W-1:0] I_ADDR,
	input wire logic [`ICS_DATA_W-1:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [`ICS_DATA_W-1:0] O_RDATA,
	output logic O_IRQ,
	input wire logic I_BUS_BUSY,
	input wire logic I_SCL_LOW_EXPIRED,
	input wire logic I_GEN_CALL,
	input wire logic I_START_SEEN,
	input wire logic I_STOP_SEEN,
	input wire logic I_ACTIVITY,
	input wire logic I_SLV_TX_DONE,
	input wire logic I_TX_ABORT,
	input wire logic I_READ_REQ,
	input wire logic I_TX_OVERFLOW,
	input wire logic I_RX_OVERFLOW,
	input wire logic I_RX_UNDERFLOW,
	input wire logic [`ICS_LVL_W-1:0] I_TX_FILL,
	input wire logic [`ICS_LVL_W-1:0] I_RX_FILL
);

	// ==========================================
	// declarations
	ics_pkg::ics_sel_t sel;
	ics_pkg::ics_evt_t evt_set;
	ics_pkg::ics_evt_t raw_flags;
	ics_pkg::ics_evt_t masked;
	ics_pkg::ics_evt_t clr_vec;
	ics_pkg::ics_evt_t mask_reg;
	ics_pkg::ics_word_t rdata_reg;
	ics_pkg::ics_word_t rdata_next;
	logic wr_isc;
	logic wr_mask;
	logic tx_low;
	logic rx_high;
	logic timeout_hit;

	ics_lvl_if tx_lvl ();
	ics_lvl_if rx_lvl ();

	// ==========================================
	// address decode
	always_comb begin
		unique case (I_ADDR)
			`ICS_OFS_MASK: begin
				sel = ics_pkg::ICS_SEL_MASK;
			end
			`ICS_OFS_RAW: begin
				sel = ics_pkg::ICS_SEL_RAW;
			end
			`ICS_OFS_ISC: begin
				sel = ics_pkg::ICS_SEL_ISC;
			end
			`ICS_OFS_TX_LVL: begin
				sel = ics_pkg::ICS_SEL_TX_LVL;
			end
			`ICS_OFS_RX_LVL: begin
				sel = ics_pkg::ICS_SEL_RX_LVL;
			end
			default: begin
				// unmapped addresses read zero and drop writes
				sel = ics_pkg::ICS_SEL_NONE;
			end
		endcase
	end

	assign wr_isc = I_WR && (sel == ics_pkg::ICS_SEL_ISC);
	assign wr_mask = I_WR && (sel == ics_pkg::ICS_SEL_MASK);

	// ==========================================
	// threshold level registers
	assign tx_lvl.wr = I_WR && (sel == ics_pkg::ICS_SEL_TX_LVL); // [RULE10]
	assign tx_lvl.wdata = I_WDATA[`ICS_LVL_W-1:0]; // [RULE10]
	assign rx_lvl.wr = I_WR && (sel == ics_pkg::ICS_SEL_RX_LVL); // [RULE11]
	assign rx_lvl.wdata = I_WDATA[`ICS_LVL_W-1:0]; // [RULE11]

	ics_level_reg #(
		.RESET_VAL(`ICS_LVL_RESET)
	) u_tx_level (
		.i_clk(I_CLK),
		.i_reset(I_RESET),
		.lvl(tx_lvl.store)
	);

	ics_level_reg #(
		.RESET_VAL(`ICS_LVL_RESET)
	) u_rx_level (
		.i_clk(I_CLK),
		.i_reset(I_RESET),
		.lvl(rx_lvl.store)
	);

	// ==========================================
	// raw event sources
	// fill comparisons are level events: while the condition holds a clear is overridden
	assign tx_low = (I_TX_FILL <= tx_lvl.level); // [RULE8] [RULE10]
	assign rx_high = (I_RX_FILL >= rx_lvl.level); // [RULE12] [RULE11]
	assign timeout_hit = I_BUS_BUSY && I_SCL_LOW_EXPIRED; // [RULE13]

	always_comb begin
		evt_set = '0;
		evt_set[`ICS_BIT_TIMEOUT] = timeout_hit; // [RULE1]
		evt_set[`ICS_BIT_GEN_CALL] = I_GEN_CALL; // [RULE4]
		evt_set[`ICS_BIT_START] = I_START_SEEN; // [RULE5]
		evt_set[`ICS_BIT_STOP] = I_STOP_SEEN; // [RULE5]
		evt_set[`ICS_BIT_ACTIVITY] = I_ACTIVITY; // [RULE6]
		evt_set[`ICS_BIT_SLV_DONE] = I_SLV_TX_DONE; // [RULE6]
		evt_set[`ICS_BIT_TX_ABORT] = I_TX_ABORT; // [RULE7]
		evt_set[`ICS_BIT_RD_REQ] = I_READ_REQ; // [RULE7]
		evt_set[`ICS_BIT_TX_LOW] = tx_low; // [RULE8]
		evt_set[`ICS_BIT_TX_OVER] = I_TX_OVERFLOW; // [RULE8]
		evt_set[`ICS_BIT_RX_HIGH] = rx_high; // [RULE9]
		evt_set[`ICS_BIT_RX_OVER] = I_RX_OVERFLOW; // [RULE9]
		evt_set[`ICS_BIT_RX_UNDER] = I_RX_UNDERFLOW; // [RULE9]
	end

	// a written one clears the raw flag, which clears the masked view with it
	assign clr_vec = wr_isc ? I_WDATA[`ICS_NUM_EVT-1:0] : '0; // [RULE14]

	// ==========================================
	// sticky raw flags
	for (genvar g = 0; g < `ICS_NUM_EVT; g++) begin : g_flag
		ics_flag #(
			.RESET_VAL(`ICS_FLAG_RESET)
		) u_flag (
			.i_clk(I_CLK),
			.i_reset(I_RESET),
			.i_set(evt_set[g]),
			.i_clr(clr_vec[g]),
			.o_flag(raw_flags[g])
		);
	end

	// ==========================================
	// interrupt mask and output
	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			mask_reg <= `ICS_MASK_RESET;
		end else if (wr_mask) begin
			mask_reg <= I_WDATA[`ICS_NUM_EVT-1:0];
		end
	end

	assign masked = raw_flags & mask_reg; // [RULE2] [RULE14]

	// level output gated from the flag and mask flops, not itself registered, high while any unmasked flag is set
	assign O_IRQ = |masked; // [RULE2]

	// ==========================================
	// read path
	always_comb begin
		rdata_next = '0;
		if (I_RD) begin
			unique case (sel)
				ics_pkg::ICS_SEL_MASK: begin
					rdata_next[`ICS_NUM_EVT-1:0] = mask_reg;
				end
				ics_pkg::ICS_SEL_RAW: begin
					rdata_next[`ICS_NUM_EVT-1:0] = raw_flags;
				end
				ics_pkg::ICS_SEL_ISC: begin
					// upper bits stay zero from the default above
					rdata_next[`ICS_NUM_EVT-1:0] = masked; // [RULE2] [RULE3]
				end
				ics_pkg::ICS_SEL_TX_LVL: begin
					rdata_next[`ICS_LVL_W-1:0] = tx_lvl.level; // [RULE10]
				end
				ics_pkg::ICS_SEL_RX_LVL: begin
					rdata_next[`ICS_LVL_W-1:0] = rx_lvl.level; // [RULE11]
				end
				ics_pkg::ICS_SEL_NONE: begin
					rdata_next = '0;
				end
			endcase
		end
	end

	// data stands only in the cycle after the read strobe, zero otherwise
	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			rdata_reg <= `ICS_RDATA_RESET;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign O_RDATA = rdata_reg;

	// ==========================================
	// checks
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RESET);

	AST_TIMEOUT_SET: assert property ( // [RULE13]
		(I_BUS_BUSY && I_SCL_LOW_EXPIRED) |=> raw_flags[`ICS_BIT_TIMEOUT]
	) else $error("timeout flag not raised by busy bus with low clock");

	AST_TIMEOUT_READ: assert property ( // [RULE1]
		(timeout_hit && mask_reg[`ICS_BIT_TIMEOUT] && !wr_mask) ##1 (I_RD && sel == ics_pkg::ICS_SEL_ISC)
		|=> O_RDATA[`ICS_BIT_TIMEOUT]
	) else $error("timeout bit 12 does not read one after the event");

	AST_MASKED_VIEW: assert property ( // [RULE2]
		(I_RD && sel == ics_pkg::ICS_SEL_ISC)
		|=> O_RDATA[`ICS_NUM_EVT-1:0] == ($past(raw_flags) & $past(mask_reg))
	) else $error("status read differs from raw flags and mask");

	AST_RESERVED_ZERO: assert property ( // [RULE3]
		I_RD |=> O_RDATA[`ICS_DATA_W-1:`ICS_NUM_EVT] == '0
	) else $error("reserved status bits read nonzero");

	AST_GEN_CALL_CLEAR: assert property ( // [RULE4]
		(wr_isc && I_WDATA[`ICS_BIT_GEN_CALL] && !I_GEN_CALL) |=> !raw_flags[`ICS_BIT_GEN_CALL]
	) else $error("general call flag survives a written one");

	AST_START_SET_WINS: assert property ( // [RULE5]
		I_START_SEEN |=> raw_flags[`ICS_BIT_START]
	) else $error("start flag lost an event during a clear");

	AST_ACTIVITY_STICKY: assert property ( // [RULE6]
		(raw_flags[`ICS_BIT_ACTIVITY] && !(wr_isc && I_WDATA[`ICS_BIT_ACTIVITY]))
		|=> raw_flags[`ICS_BIT_ACTIVITY]
	) else $error("activity flag dropped without a clear");

	AST_ABORT_IRQ: assert property ( // [RULE7]
		(I_TX_ABORT && mask_reg[`ICS_BIT_TX_ABORT] && !wr_mask) |=> O_IRQ
	) else $error("unmasked transmit abort did not raise the interrupt");

	AST_TX_LOW_SET: assert property ( // [RULE8]
		(I_TX_FILL <= tx_lvl.level) |=> raw_flags[`ICS_BIT_TX_LOW]
	) else $error("transmit low flag not raised at or below level");

	AST_RX_OVER_SET: assert property ( // [RULE9]
		I_RX_OVERFLOW |=> raw_flags[`ICS_BIT_RX_OVER]
	) else $error("receive overflow flag not raised");

	AST_TX_LEVEL_WRITE: assert property ( // [RULE10]
		(I_WR && I_ADDR == `ICS_OFS_TX_LVL) ##1 (I_RD && I_ADDR == `ICS_OFS_TX_LVL)
		|=> O_RDATA == {24'h00_0000, $past(I_WDATA[`ICS_LVL_W-1:0], 2)}
	) else $error("transmit level did not read back as written");

	AST_RX_LEVEL_WRITE: assert property ( // [RULE11]
		(I_WR && I_ADDR == `ICS_OFS_RX_LVL) |=> rx_lvl.level == $past(I_WDATA[`ICS_LVL_W-1:0])
	) else $error("receive level register did not take the write");

	AST_RX_HIGH_SET: assert property ( // [RULE12]
		(I_RX_FILL >= rx_lvl.level) |=> raw_flags[`ICS_BIT_RX_HIGH]
	) else $error("receive high flag not raised at or above level");

	AST_CLEAR_BOTH: assert property ( // [RULE14]
		(wr_isc && I_WDATA[`ICS_BIT_STOP] && !I_STOP_SEEN) |=> !raw_flags[`ICS_BIT_STOP] && !masked[`ICS_BIT_STOP]
	) else $error("clear left the stop flag set in a view");

endmodule

// ==== tb/tb.sv ====
// self-checking bench for the interrupt status, mask and threshold level registers
`include "ics_consts.svh"
`define CHK(name, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
	$display("ERROR %s expected %h seen %h", name, exp, got); end end

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================
	// stimulus and observed signals
	logic I_CLK = 1'b0;
	logic I_RESET = 1'b1;
	logic [7:0] I_ADDR = 8'h00;
	logic [31:0] I_WDATA = 32'h0000_0000;
	logic I_WR = 1'b0;
	logic I_RD = 1'b0;
	logic [31:0] O_RDATA;
	logic O_IRQ;
	logic busy = 1'b0;
	logic expired = 1'b0;
	logic [12:0] evt = 13'h0000;
	logic [7:0] tx_fill = 8'hff;
	logic [7:0] rx_fill = 8'h00;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	always #2 I_CLK = ~I_CLK;

	ics_top ics_top_i (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
		.I_RD(I_RD), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ), .I_BUS_BUSY(busy), .I_SCL_LOW_EXPIRED(expired),
		.I_GEN_CALL(evt[11]), .I_START_SEEN(evt[10]), .I_STOP_SEEN(evt[9]), .I_ACTIVITY(evt[8]),
		.I_SLV_TX_DONE(evt[7]), .I_TX_ABORT(evt[6]), .I_READ_REQ(evt[5]), .I_TX_OVERFLOW(evt[3]),
		.I_RX_OVERFLOW(evt[1]), .I_RX_UNDERFLOW(evt[0]), .I_TX_FILL(tx_fill), .I_RX_FILL(rx_fill));

	// ==========================================
	// bus and event helpers
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_WDATA <= d;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
		// step off the edge so callers see the register already updated
		#1;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string name);
		@(posedge I_CLK);
		I_ADDR <= a;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1;
		`CHK(name, exp, O_RDATA)
	endtask

	// bit 12 stands for busy and expired together, the timeout condition
	task automatic pulse(input logic [12:0] v);
		@(posedge I_CLK);
		evt <= v;
		busy <= v[12];
		expired <= v[12];
		@(posedge I_CLK);
		evt <= 13'h0000;
		busy <= 1'b0;
		expired <= 1'b0;
		#1;
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		`CHK("irq after reset", 1'b0, O_IRQ)
		chk_rd(`ICS_OFS_TX_LVL, 32'h0000_0000, "tx level reset");
		chk_rd(`ICS_OFS_RX_LVL, 32'h0000_0000, "rx level reset");
		chk_rd(`ICS_OFS_ISC, 32'h0000_0000, "status masked at reset");
		chk_rd(`ICS_OFS_RAW, 32'h0000_0004, "raw with empty rx fifo");
		wr(`ICS_OFS_RX_LVL, 32'h0000_00ff);
		wr(`ICS_OFS_ISC, 32'h0000_1fff);
		chk_rd(`ICS_OFS_RAW, 32'h0000_0000, "raw after clear all");
		wr(`ICS_OFS_MASK, 32'h0000_1fff);
	endtask

	task automatic t_events();
		logic [31:0] b;
		for (int i = 0; i < 13; i++) begin
			if (i != 2 && i != 4) begin
				b = 32'h0000_0001 << i;
				pulse(b[12:0]);
				`CHK("irq on event", 1'b1, O_IRQ)
				chk_rd(`ICS_OFS_ISC, b, "status after event");
				// zeros in the flag's own place and ones elsewhere must leave it standing
				wr(`ICS_OFS_ISC, ~b);
				chk_rd(`ICS_OFS_ISC, b, "status after other ones");
				wr(`ICS_OFS_ISC, b);
				chk_rd(`ICS_OFS_RAW, 32'h0000_0000, "raw after clear");
				`CHK("irq after clear", 1'b0, O_IRQ)
			end
		end
	endtask

	task automatic t_timeout();
		@(posedge I_CLK);
		busy <= 1'b1;
		@(posedge I_CLK);
		busy <= 1'b0;
		expired <= 1'b1;
		@(posedge I_CLK);
		expired <= 1'b0;
		chk_rd(`ICS_OFS_RAW, 32'h0000_0000, "busy or expired alone");
		// timeout condition for one cycle, status read in the very next cycle
		@(posedge I_CLK);
		busy <= 1'b1;
		expired <= 1'b1;
		@(posedge I_CLK);
		busy <= 1'b0;
		expired <= 1'b0;
		I_ADDR <= `ICS_OFS_ISC;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1;
		`CHK("timeout read next cycle", 32'h0000_1000, O_RDATA)
		wr(`ICS_OFS_ISC, 32'h0000_1000);
		chk_rd(`ICS_OFS_RAW, 32'h0000_0000, "timeout cleared");
	endtask

	task automatic t_mask();
		wr(`ICS_OFS_MASK, 32'h0000_0000);
		pulse(13'h0400);
		`CHK("irq masked", 1'b0, O_IRQ)
		chk_rd(`ICS_OFS_ISC, 32'h0000_0000, "status masked");
		chk_rd(`ICS_OFS_RAW, 32'h0000_0400, "raw under mask");
		wr(`ICS_OFS_MASK, 32'h0000_1fff);
		`CHK("irq unmasked", 1'b1, O_IRQ)
		chk_rd(`ICS_OFS_ISC, 32'h0000_0400, "status unmasked");
		wr(`ICS_OFS_ISC, 32'h0000_0400);
		chk_rd(`ICS_OFS_RAW, 32'h0000_0000, "raw after masked clear");
	endtask

	task automatic t_levels();
		// write and read back with no gap between the strobes
		@(posedge I_CLK);
		I_ADDR <= `ICS_OFS_TX_LVL;
		I_WDATA <= 32'hffff_ff05;
		I_WR <= 1'b1;
		@(posedge I_CLK);
		I_WR <= 1'b0;
		I_RD <= 1'b1;
		@(posedge I_CLK);
		I_RD <= 1'b0;
		#1;
		`CHK("tx level field", 32'h0000_0005, O_RDATA)
		tx_fill <= 8'h06;
		chk_rd(`ICS_OFS_ISC, 32'h0000_0000, "tx fill above level");
		tx_fill <= 8'h05;
		chk_rd(`ICS_OFS_ISC, 32'h0000_0010, "tx fill at level");
		tx_fill <= 8'hff;
		wr(`ICS_OFS_ISC, 32'h0000_0010);
		chk_rd(`ICS_OFS_ISC, 32'h0000_0000, "tx low cleared");
		wr(`ICS_OFS_RX_LVL, 32'habcd_ff07);
		chk_rd(`ICS_OFS_RX_LVL, 32'h0000_0007, "rx level field");
		rx_fill <= 8'h06;
		chk_rd(`ICS_OFS_ISC, 32'h0000_0000, "rx fill below level");
		rx_fill <= 8'h07;
		chk_rd(`ICS_OFS_ISC, 32'h0000_0004, "rx fill at level");
		rx_fill <= 8'h00;
		wr(`ICS_OFS_ISC, 32'h0000_0004);
		chk_rd(`ICS_OFS_ISC, 32'h0000_0000, "rx high cleared");
	endtask

	task automatic t_reserved();
		pulse(13'h1000);
		wr(`ICS_OFS_ISC, 32'hffff_e000);
		chk_rd(`ICS_OFS_ISC, 32'h0000_1000, "upper bits zero");
		@(posedge I_CLK);
		#1;
		`CHK("rdata idle", 32'h0000_0000, O_RDATA)
		chk_rd(8'h48, 32'h0000_0000, "unmapped read");
		wr(`ICS_OFS_ISC, 32'hffff_ffff);
		chk_rd(`ICS_OFS_ISC, 32'h0000_0000, "all cleared");
	endtask

	// ==========================================
	// run control
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// the whole sequence needs well under a thousand cycles
	always @(posedge I_CLK) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			stop_test();
		end
	end

	initial begin
		repeat (6) @(posedge I_CLK);
		I_RESET <= 1'b0;
		t_reset();
		t_events();
		t_timeout();
		t_mask();
		t_levels();
		t_reserved();
		stop_test();
	end
endmodule
